// ===== eamr_pkg.sv
`default_nettype none
package eamr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int SETTLE_MS = 125;
  localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  localparam int MCLK_HZ = 4_096_000;
  localparam int CAL_HOLD_MCLK = 5; // strictly more than four master clocks
  localparam int CAL_HOLD_CYC = (CAL_HOLD_MCLK * CLK_HZ + MCLK_HZ - 1) / MCLK_HZ;
  localparam int SCLK_HALF_CYC = 8;
  localparam int SCLK_HALF_MIN = 4; // two sync flops plus the bus write register and the port register
  localparam int READY_GUARD_CYC = 4; // sync flops plus the converter reacting to calibrate
  localparam int RES_W = 20;
  // ---------------------------------------------------------------
  // board address map
  // ---------------------------------------------------------------
  localparam logic [3:0] REGION_BASE = 4'hc;
  localparam logic [1:0] SINGLE_BOARD = 2'h3;
  localparam logic [11:0] OFF_PORT_A = 12'h000;
  localparam logic [11:0] OFF_PORT_B = 12'h001;
  localparam logic [11:0] OFF_PORT_C = 12'h002;
  localparam logic [11:0] OFF_CTRL = 12'h003;
  localparam logic [11:0] OFF_MUX = 12'h010;
  // ---------------------------------------------------------------
  // parallel interface control word, basic mode
  // ---------------------------------------------------------------
  localparam logic [7:0] CW_MODE0 = 8'h80;
  localparam int CW_A_IN = 4;
  localparam int CW_CHI_IN = 3;
  localparam int CW_B_IN = 1;
  localparam int CW_CLO_IN = 0;
  // direction vector bits, 1 = input
  localparam int DIR_A = 0;
  localparam int DIR_B = 1;
  localparam int DIR_CHI = 2;
  localparam int DIR_CLO = 3;
  // ---------------------------------------------------------------
  // port A lines to the converter, input lines from it
  // ---------------------------------------------------------------
  localparam int PA_RANGE = 0;
  localparam int PA_CAL = 1;
  localparam int PA_CS = 2;
  localparam int PA_SC2 = 3;
  localparam int PA_SCLK = 4;
  localparam int PA_SC1 = 5;
  localparam logic [7:0] PA_RESET = 8'h04; // chip select idle high
  localparam int IN_SERIAL_RESULT_LINE = 0;
  localparam int IN_RDY_N = 1;
  // calibration type {cal_type_sel_hi, cal_type_sel_lo}
  localparam logic [1:0] SC_SELF = 2'b00;
  localparam logic [1:0] SC_OFFSET = 2'b11;
  localparam logic [1:0] SC_GAIN = 2'b01;
  localparam logic [1:0] SC_ONESTEP = 2'b10;
  localparam logic [1:0] CAL_MODE_BAD = 2'd3;
  localparam logic [1:0] CH_OFFSET = 2'd1;
  localparam logic [1:0] CH_GAIN = 2'd2;
  localparam logic [1:0] CH_SIGNAL = 2'd0;

  typedef enum logic [2:0] {CMD_INIT, CMD_MUX, CMD_CONV, CMD_CAL, CMD_READ} eamr_cmd_t;

  // board index to a full bus address
  function automatic logic [15:0] eamr_addr(input logic [1:0] rgn, input logic [11:0] off);
    eamr_addr = {REGION_BASE + {2'b00, rgn}, off};
  endfunction

  // basic-mode control word from the direction vector
  function automatic logic [7:0] eamr_ctrl_word(input logic [3:0] dir);
    logic [7:0] w;
    w = CW_MODE0;
    w[CW_A_IN] = dir[DIR_A];
    w[CW_CHI_IN] = dir[DIR_CHI];
    w[CW_B_IN] = dir[DIR_B];
    w[CW_CLO_IN] = dir[DIR_CLO];
    eamr_ctrl_word = w;
  endfunction
endpackage
`default_nettype wire

// ===== eamr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module eamr_sync #(
  parameter int W = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  // two-stage catcher; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= '1;
      o_sync <= '1;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== eamr_tick.sv
`timescale 1ns/1ps
`default_nettype none
module eamr_tick #(
  parameter int DIV = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  output logic o_tick
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;

  initial begin
    if (DIV < 2) $error("divider too small");
  end

  // free-running divider, one-cycle enable per period
  always_comb begin
    next_tick = (cnt == CW'(DIV - 1));
    next_cnt = next_tick ? '0 : cnt + CW'(1);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ===== eamr_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - board index 0 to 3 maps to address regions C, D, E, F.
// - default node selects stored board; default flag stores the given index.
// - parallel interface set up in basic mode, four independent port directions.
// - after a mode change write every output port; low eight bits only.
// - each value bit is one line, 1 high and 0 low.
// - channel above 3 is rejected with error; multiplexer untouched.
// - select 0-3 unipolar channel, 4-7 bipolar channel.
// - ready sensed on input bit 1, low means result ready.
// - mode 0 self calibration leaves the multiplexer alone.
// - mode 1 uses channel 1 offset step, channel 2 gain step, then 0.
// - mode 2 one-step offset on the current channel.
// - calibration finishes only on ready; mode 3 is an error.
// - a read waits for ready, then samples data twenty times.
// - wait the 125 ms step response after any channel change.
// - port A bit 0 range, 1 calibrate, 2 chip select, 4 serial clock.
// - calibrate line held high over four master clocks.
// - calibration type on bits 5 and 3: 00, 11, 01, 10.
// - chip select low gives MSB first; bits change on falling clock.
module eamr_top
  import eamr_pkg::*;
#(
  parameter int SETTLE = eamr_pkg::SETTLE_CYC,
  parameter int SCLK_HALF = eamr_pkg::SCLK_HALF_CYC,
  parameter int CNT_W = 24
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cmd_valid,
  input wire eamr_pkg::eamr_cmd_t i_cmd,
  input wire logic [1:0] i_node,
  input wire logic i_node_dflt,
  input wire logic i_set_default,
  input wire logic [2:0] i_chan,
  input wire logic [1:0] i_cal_mode,
  input wire logic [3:0] i_port_dir,
  input wire logic [7:0] i_val_a,
  input wire logic [7:0] i_val_b,
  input wire logic [3:0] i_val_c_hi,
  input wire logic [3:0] i_val_c_lo,
  input wire logic [1:0] i_buffered_input_port,
  output logic o_bus_wr,
  output logic [15:0] o_bus_addr,
  output logic [7:0] o_bus_data,
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  output logic [eamr_pkg::RES_W-1:0] o_result,
  output logic o_conv_ready,
  output logic [1:0] o_default_board
);
  import eamr_pkg::*;

  initial begin
    if (SCLK_HALF < SCLK_HALF_MIN) $error("serial half period too short");
    if (SETTLE < 1 || SETTLE >= (1 << CNT_W)) $error("settle count does not fit");
    if (CAL_HOLD_CYC >= (1 << CNT_W)) $error("hold count does not fit");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_CTRL, ST_PORT, ST_RANGE, ST_MUX, ST_SETTLE, ST_CAL_HI,
    ST_CAL_WAIT, ST_RD_WAIT, ST_RD_RISE, ST_RD_HIGH, ST_RD_END, ST_DONE
  } eamr_state_t;

  // ---------------------------------------------------------------
  // pin inputs and serial clock enable
  // ---------------------------------------------------------------
  logic [1:0] in_s;
  logic tick;
  eamr_sync #(.W(2)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(i_buffered_input_port),
    .o_sync(in_s)
  );
  eamr_tick #(.DIV(SCLK_HALF)) u_tick (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_tick(tick)
  );
  logic result_ready_n;
  logic serial_result_line;
  assign result_ready_n = in_s[IN_RDY_N];
  assign serial_result_line = in_s[IN_SERIAL_RESULT_LINE];

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  eamr_state_t state, next_state;
  eamr_cmd_t op, next_op;
  logic [1:0] rgn, next_rgn;
  logic [1:0] default_board_record, next_default_board_record;
  logic [7:0] porta, next_porta;
  logic [1:0] chan, next_chan;
  logic [1:0] cal_mode, next_cal_mode;
  logic [1:0] cal_step, next_cal_step;
  logic [1:0] port_idx, next_port_idx;
  logic [3:0] dir, next_dir;
  logic [23:0] vals, next_vals;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [4:0] bitn, next_bitn;
  logic [RES_W-1:0] shift, next_shift;
  logic next_wr, next_busy, next_done, next_error, wr_pa;
  logic [15:0] next_addr;
  logic [7:0] next_data;
  logic [RES_W-1:0] next_result;
  logic [1:0] node_eff;

  // next-state and bus-write computation
  always_comb begin
    next_state = state;
    next_op = op;
    next_rgn = rgn;
    next_default_board_record = default_board_record;
    next_porta = porta;
    next_chan = chan;
    next_cal_mode = cal_mode;
    next_cal_step = cal_step;
    next_port_idx = port_idx;
    next_dir = dir;
    next_vals = vals;
    next_cnt = cnt;
    next_bitn = bitn;
    next_shift = shift;
    next_wr = 1'b0;
    next_addr = o_bus_addr;
    next_data = o_bus_data;
    next_busy = o_busy;
    next_done = 1'b0;
    next_error = o_error;
    next_result = o_result;
    wr_pa = 1'b0;
    node_eff = i_node_dflt ? default_board_record : i_node;
    unique case (state)
      ST_IDLE: begin
        if (i_cmd_valid) begin
          next_rgn = node_eff;
          if (i_set_default) next_default_board_record = node_eff;
          next_op = i_cmd;
          next_busy = 1'b1;
          next_error = 1'b0;
          next_cal_mode = i_cal_mode;
          next_cal_step = 2'd0;
          next_dir = i_port_dir;
          next_vals = {i_val_a, i_val_b, i_val_c_hi, i_val_c_lo};
          unique case (i_cmd)
            CMD_INIT: next_state = ST_CTRL;
            CMD_MUX: begin
              if (i_chan[2]) begin
                next_error = 1'b1;
                next_state = ST_DONE;
              end else begin
                next_chan = i_chan[1:0];
                next_state = ST_MUX;
              end
            end
            CMD_CONV: begin
              next_chan = i_chan[1:0];
              next_porta[PA_RANGE] = i_chan[2];
              next_state = ST_RANGE;
            end
            CMD_CAL: begin
              if (i_cal_mode == CAL_MODE_BAD) begin
                next_error = 1'b1;
                next_state = ST_DONE;
              end else if (i_cal_mode == 2'd1) begin
                next_chan = CH_OFFSET;
                next_state = ST_MUX;
              end else begin
                {next_porta[PA_SC1], next_porta[PA_SC2]} = i_cal_mode[1] ? SC_ONESTEP : SC_SELF;
                next_porta[PA_CAL] = 1'b1;
                wr_pa = 1'b1;
                next_cnt = CNT_W'(CAL_HOLD_CYC);
                next_state = ST_CAL_HI;
              end
            end
            CMD_READ: next_state = ST_RD_WAIT;
            default: begin
              next_error = 1'b1;
              next_state = ST_DONE;
            end
          endcase
        end
      end
      // mode word first; the board then holds all outputs low
      ST_CTRL: begin
        next_wr = 1'b1;
        next_addr = eamr_addr(rgn, OFF_CTRL);
        next_data = eamr_ctrl_word(dir);
        next_port_idx = 2'd0;
        next_state = ST_PORT;
      end
      // restore each output port straight after the mode change
      ST_PORT: begin
        next_port_idx = port_idx + 2'd1;
        unique case (port_idx)
          2'd0: begin
            if (!dir[DIR_A]) begin
              next_wr = 1'b1;
              next_addr = eamr_addr(rgn, OFF_PORT_A);
              next_data = vals[23:16];
              next_porta = vals[23:16];
            end
          end
          2'd1: begin
            if (!dir[DIR_B]) begin
              next_wr = 1'b1;
              next_addr = eamr_addr(rgn, OFF_PORT_B);
              next_data = vals[15:8];
            end
          end
          default: begin
            if (!dir[DIR_CHI] || !dir[DIR_CLO]) begin
              next_wr = 1'b1;
              next_addr = eamr_addr(rgn, OFF_PORT_C);
              next_data = vals[7:0];
            end
            next_state = ST_DONE;
          end
        endcase
      end
      ST_RANGE: begin
        wr_pa = 1'b1;
        next_state = ST_MUX;
      end
      ST_MUX: begin
        next_wr = 1'b1;
        next_addr = eamr_addr(rgn, OFF_MUX);
        next_data = {6'h00, chan};
        next_cnt = CNT_W'(SETTLE);
        next_state = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (cnt != '0) begin
          next_cnt = cnt - CNT_W'(1);
        end else if (op == CMD_CAL && cal_step != 2'd2) begin
          {next_porta[PA_SC1], next_porta[PA_SC2]} = (cal_step == 2'd0) ? SC_OFFSET : SC_GAIN;
          next_porta[PA_CAL] = 1'b1;
          wr_pa = 1'b1;
          next_cnt = CNT_W'(CAL_HOLD_CYC);
          next_state = ST_CAL_HI;
        end else begin
          next_state = ST_DONE;
        end
      end
      ST_CAL_HI: begin
        if (cnt != '0) begin
          next_cnt = cnt - CNT_W'(1);
        end else begin
          next_porta[PA_CAL] = 1'b0;
          wr_pa = 1'b1;
          next_cnt = CNT_W'(READY_GUARD_CYC);
          next_state = ST_CAL_WAIT;
        end
      end
      // no completion until the converter reports ready; the guard skips
      // the stale ready level still in the sync flops after calibrate falls
      ST_CAL_WAIT: begin
        if (cnt != '0) begin
          next_cnt = cnt - CNT_W'(1);
        end else if (!result_ready_n) begin
          if (cal_mode == 2'd1) begin
            next_cal_step = cal_step + 2'd1;
            next_chan = (cal_step == 2'd0) ? CH_GAIN : CH_SIGNAL;
            next_state = ST_MUX;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_RD_WAIT: begin
        if (!result_ready_n) begin
          next_porta[PA_CS] = 1'b0;
          next_porta[PA_SCLK] = 1'b0;
          wr_pa = 1'b1;
          next_bitn = 5'd0;
          next_state = ST_RD_RISE;
        end
      end
      ST_RD_RISE: begin
        if (tick) begin
          next_porta[PA_SCLK] = 1'b1;
          wr_pa = 1'b1;
          next_state = ST_RD_HIGH;
        end
      end
      // sample before the falling edge moves the line on
      ST_RD_HIGH: begin
        if (tick) begin
          next_shift = {shift[RES_W-2:0], serial_result_line};
          next_porta[PA_SCLK] = 1'b0;
          wr_pa = 1'b1;
          if (bitn == 5'(RES_W - 1)) begin
            next_state = ST_RD_END;
          end else begin
            next_bitn = bitn + 5'd1;
            next_state = ST_RD_RISE;
          end
        end
      end
      ST_RD_END: begin
        next_porta[PA_CS] = 1'b1;
        wr_pa = 1'b1;
        next_result = shift;
        next_state = ST_DONE;
      end
      ST_DONE: begin
        next_done = 1'b1;
        next_busy = 1'b0;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (wr_pa) begin
      next_wr = 1'b1;
      next_addr = eamr_addr(next_rgn, OFF_PORT_A);
      next_data = next_porta;
    end
  end

  // registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      op <= CMD_INIT;
      rgn <= SINGLE_BOARD;
      default_board_record <= SINGLE_BOARD;
      porta <= PA_RESET;
      chan <= 2'd0;
      cal_mode <= 2'd0;
      cal_step <= 2'd0;
      port_idx <= 2'd0;
      dir <= 4'h0;
      vals <= 24'h000000;
      cnt <= '0;
      bitn <= 5'd0;
      shift <= '0;
      o_bus_wr <= 1'b0;
      o_bus_addr <= 16'h0000;
      o_bus_data <= 8'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_error <= 1'b0;
      o_result <= '0;
      o_conv_ready <= 1'b0;
      o_default_board <= SINGLE_BOARD;
    end else begin
      state <= next_state;
      op <= next_op;
      rgn <= next_rgn;
      default_board_record <= next_default_board_record;
      porta <= next_porta;
      chan <= next_chan;
      cal_mode <= next_cal_mode;
      cal_step <= next_cal_step;
      port_idx <= next_port_idx;
      dir <= next_dir;
      vals <= next_vals;
      cnt <= next_cnt;
      bitn <= next_bitn;
      shift <= next_shift;
      o_bus_wr <= next_wr;
      o_bus_addr <= next_addr;
      o_bus_data <= next_data;
      o_busy <= next_busy;
      o_done <= next_done;
      o_error <= next_error;
      o_result <= next_result;
      o_conv_ready <= !result_ready_n;
      o_default_board <= next_default_board_record;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  localparam int HOLD_LAST = 0;

  sequence s_err_done;
    ##1 (state == ST_DONE && !o_bus_wr) ##1 (o_done && o_error && !o_bus_wr);
  endsequence
  sequence s_conv_pa_wr;
    ##2 (o_bus_wr && o_bus_addr[11:0] == OFF_PORT_A);
  endsequence

  bad_mode_a: assert property (
    (state == ST_IDLE && i_cmd_valid && i_cmd == CMD_CAL && i_cal_mode == CAL_MODE_BAD)
    |-> s_err_done) else $error("bad calibration mode not refused");
  bad_chan_a: assert property (
    (state == ST_IDLE && i_cmd_valid && i_cmd == CMD_MUX && i_chan[2])
    |-> s_err_done) else $error("bad channel not refused");
  region_map_a: assert property (
    o_bus_wr |-> o_bus_addr[15:12] == REGION_BASE + {2'b00, rgn})
    else $error("write outside board region");
  default_node_a: assert property (
    (state == ST_IDLE && i_cmd_valid && i_node_dflt)
    |=> rgn == $past(default_board_record)) else $error("default board not used");
  conv_range_a: assert property (
    (state == ST_IDLE && i_cmd_valid && i_cmd == CMD_CONV)
    |-> s_conv_pa_wr ##0 (o_bus_data[PA_RANGE] == $past(i_chan[2], 2)))
    else $error("range line wrong");
  settle_load_a: assert property (
    (state == ST_MUX) |=> (state == ST_SETTLE && cnt == CNT_W'(SETTLE)))
    else $error("settle not started");
  cal_hold_a: assert property (
    $fell(porta[PA_CAL]) |-> ($past(state) == ST_CAL_HI && $past(cnt) == HOLD_LAST))
    else $error("calibrate pulse cut short");
  cal_wait_a: assert property (
    (state == ST_CAL_WAIT && result_ready_n) |=> state == ST_CAL_WAIT)
    else $error("calibration left before ready");
  sample_high_a: assert property (
    (state == ST_RD_HIGH && tick) |-> (porta[PA_SCLK] && !porta[PA_CS]))
    else $error("sample not taken with clock high");
  onestep_type_a: assert property (
    ($rose(porta[PA_CAL]) && cal_mode == 2'd2)
    |-> {porta[PA_SC1], porta[PA_SC2]} == SC_ONESTEP) else $error("calibration type wrong");
endmodule
`default_nettype wire

// ===== eamr_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module eamr_conv_model
  import eamr_pkg::*;
#(
  parameter logic [3:0] RGN = 4'hf,
  parameter logic [7:0] CAL_BUSY = 8'h28
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_bus_wr,
  input wire logic [15:0] i_bus_addr,
  input wire logic [7:0] i_bus_data,
  input wire logic [19:0] i_word,
  input wire logic i_load,
  output logic [1:0] o_port
);
  logic [7:0] pa, next_pa;
  logic [19:0] sh, next_sh;
  logic [4:0] nbit, next_nbit;
  logic spent, next_spent;
  logic [7:0] busy, next_busy;
  logic tog;
  logic sel;
  logic [7:0] d;
  // ----------------------------------------
  // board decode, port A lines, serial word
  // ----------------------------------------
  // a jumperless board answers only in region F
  assign sel = i_bus_wr && i_bus_addr[15:12] == RGN;
  assign d = i_bus_data;
  always_comb begin
    next_pa = pa;
    next_sh = sh;
    next_nbit = nbit;
    next_spent = i_load ? 1'b0 : spent;
    next_busy = (busy != 8'h00) ? busy - 8'h01 : busy;
    // a mode change pulls every output line low
    if (sel && i_bus_addr[11:0] == OFF_CTRL) next_pa = 8'h00;
    if (sel && i_bus_addr[11:0] == OFF_PORT_A) begin
      next_pa = d;
      // chip select falling puts the msb on the line
      if (pa[PA_CS] && !d[PA_CS]) begin
        next_sh = i_word;
        next_nbit = 5'h00;
      end
      // later bits move on each falling serial clock
      if (!d[PA_CS] && pa[PA_SCLK] && !d[PA_SCLK]) begin
        next_sh = {sh[18:0], 1'b0};
        next_nbit = nbit + 5'h01;
        next_spent = spent || nbit == 5'h13;
      end
      // calibrate falling: converter resets and stays busy a while
      if (pa[PA_CAL] && !d[PA_CAL]) begin
        next_busy = CAL_BUSY;
        next_spent = 1'b0;
      end
    end
  end
  // registers only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pa <= PA_RESET;
      sh <= 20'h00000;
      nbit <= 5'h00;
      spent <= 1'b0;
      busy <= 8'h00;
      tog <= 1'b0;
    end else begin
      pa <= next_pa;
      sh <= next_sh;
      nbit <= next_nbit;
      spent <= next_spent;
      busy <= next_busy;
      tog <= ~tog;
    end
  end
  // released lines change every cycle so no stale level can be mistaken
  assign o_port[IN_RDY_N] = spent ? tog : (busy != 8'h00);
  assign o_port[IN_SERIAL_RESULT_LINE] = (!pa[PA_CS] && !spent) ? sh[19] : tog;
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import eamr_pkg::*;
  // ----------------------------------------
  // stimulus, clock and board write log
  // ----------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  eamr_cmd_t cmd = CMD_INIT;
  logic [1:0] node = 2'h3;
  logic node_dflt = 1'b0;
  logic set_default = 1'b0;
  logic [2:0] chan = 3'h0;
  logic [1:0] cal_mode = 2'h0;
  logic [3:0] port_dir = 4'h0;
  logic [23:0] vals = 24'h043ca5;
  logic [19:0] word = 20'h00000;
  logic load = 1'b0;
  logic [1:0] pins;
  logic bus_wr, busy, done, error, conv_ready;
  logic [15:0] bus_addr;
  logic [7:0] bus_data;
  logic [19:0] result;
  logic [1:0] dflt_b;
  logic [23:0] wq[$];
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int lat;
  always #20 clk = ~clk;
  // short settle keeps the run small
  eamr_top #(.SETTLE(20), .SCLK_HALF(4)) u_eamr_top (
    .i_clk(clk), .i_rstn(rstn), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_node(node),
    .i_node_dflt(node_dflt), .i_set_default(set_default), .i_chan(chan),
    .i_cal_mode(cal_mode), .i_port_dir(port_dir), .i_val_a(vals[23:16]),
    .i_val_b(vals[15:8]), .i_val_c_hi(vals[7:4]), .i_val_c_lo(vals[3:0]),
    .i_buffered_input_port(pins), .o_bus_wr(bus_wr), .o_bus_addr(bus_addr),
    .o_bus_data(bus_data), .o_busy(busy), .o_done(done), .o_error(error),
    .o_result(result), .o_conv_ready(conv_ready), .o_default_board(dflt_b));
  eamr_conv_model u_eamr_conv_model (
    .i_clk(clk), .i_rstn(rstn), .i_bus_wr(bus_wr), .i_bus_addr(bus_addr),
    .i_bus_data(bus_data), .i_word(word), .i_load(load), .o_port(pins));
  always @(posedge clk) begin
    if (bus_wr === 1'b1) wq.push_back({bus_addr, bus_data});
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      errors++;
      complete_run();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic exp_wr(input logic [23:0] exp);
    logic [23:0] got;
    got = (wq.size() > 0) ? wq.pop_front() : 24'hxxxxxx;
    check("bus write", {8'h00, got}, {8'h00, exp});
  endtask
  // one command, waits for its done pulse
  task automatic run(input eamr_cmd_t c, input logic [1:0] n, input logic [2:0] ch,
                     input logic [1:0] m);
    @(negedge clk);
    wq.delete();
    cmd = c;
    node = n;
    chan = ch;
    cal_mode = m;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (lat = 1; lat < 5000 && done !== 1'b1; lat++) @(negedge clk);
    if (lat >= 5000) check("done", 1'b0, 1'b1);
  endtask
  task automatic complete_run();
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("default board", dflt_b, 2'h3);
    check("busy", busy, 1'b0);
    check("result", result, 20'h00000);
  endtask
  task automatic t_init(input logic [1:0] n, input logic [3:0] dir);
    logic [3:0] rg;
    rg = 4'hc + {2'b00, n};
    port_dir = dir;
    run(CMD_INIT, n, 3'h0, 2'h0);
    exp_wr({rg, OFF_CTRL, 8'h80 | {3'h0, dir[0], dir[2], 1'b0, dir[1], dir[3]}});
    if (!dir[0]) exp_wr({rg, OFF_PORT_A, vals[23:16]});
    if (!dir[1]) exp_wr({rg, OFF_PORT_B, vals[15:8]});
    if (!(dir[2] && dir[3])) exp_wr({rg, OFF_PORT_C, vals[7:0]});
    check("extra writes", wq.size(), 0);
  endtask
  task automatic t_mux();
    for (int n = 0; n < 4; n++) begin
      set_default = (n == 1);
      run(CMD_MUX, n[1:0], {1'b0, n[1:0] ^ 2'h1}, 2'h0);
      set_default = 1'b0;
      exp_wr({4'hc + n[3:0], OFF_MUX, 6'h00, n[1:0] ^ 2'h1});
      check("mux error", error, 1'b0);
    end
    check("stored default", dflt_b, 2'h1);
    run(CMD_MUX, 2'h3, 3'h5, 2'h0);
    check("bad channel error", error, 1'b1);
    check("bad channel writes", wq.size(), 0);
  endtask
  task automatic t_default();
    node_dflt = 1'b1;
    run(CMD_MUX, 2'h0, 3'h2, 2'h0);
    exp_wr({4'hd, OFF_MUX, 8'h02});
    node_dflt = 1'b0;
    set_default = 1'b1;
    run(CMD_MUX, 2'h3, 3'h0, 2'h0);
    set_default = 1'b0;
    check("stored default", dflt_b, 2'h3);
  endtask
  // ends on unipolar so later port A values carry range low
  task automatic t_conv();
    for (int c = 7; c >= 0; c--) begin
      run(CMD_CONV, 2'h3, c[2:0], 2'h0);
      exp_wr({4'hf, OFF_PORT_A, 7'h02, c[2]});
      exp_wr({4'hf, OFF_MUX, 6'h00, c[1:0]});
    end
  endtask
  // channel and type histories packed behind a marker bit
  task automatic t_cal(input logic [1:0] m, input logic [7:0] mx_exp, input logic [7:0] ty_exp);
    logic [7:0] mx;
    logic [7:0] ty;
    logic [23:0] w;
    mx = 8'h01;
    ty = 8'h01;
    run(CMD_CAL, 2'h3, 3'h0, m);
    while (wq.size() > 0) begin
      w = wq.pop_front();
      if (w[19:8] == OFF_MUX) mx = {mx[5:0], w[1:0]};
      if (w[19:8] == OFF_PORT_A && w[PA_CAL]) ty = {ty[5:0], w[PA_SC1], w[PA_SC2]};
    end
    check("cal channels", mx, mx_exp);
    check("cal types", ty, ty_exp);
    check("cal waits ready", lat > 65, 1'b1);
    check("cal error", error, 1'b0);
  endtask
  task automatic t_cal_bad();
    run(CMD_CAL, 2'h3, 3'h0, 2'h3);
    check("bad mode error", error, 1'b1);
    check("bad mode writes", wq.size(), 0);
  endtask
  task automatic t_read(input logic [19:0] w);
    @(negedge clk);
    word = w;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    repeat (4) @(negedge clk);
    check("ready flag", conv_ready, 1'b1);
    run(CMD_READ, 2'h3, 3'h0, 2'h0);
    check("result", result, w);
    check("serial writes", wq.size(), 42);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_init(2'h0, 4'b1100);
    t_init(2'h3, 4'b0010);
    t_mux();
    t_default();
    t_conv();
    t_cal(2'h0, 8'h01, 8'h04);
    t_cal(2'h2, 8'h01, 8'h06);
    t_cal(2'h1, 8'h58, 8'h1d);
    t_cal_bad();
    t_read(20'ha5c3e);
    t_read(20'h80001);
    t_read(20'h7ffff);
    complete_run();
  end
endmodule
`default_nettype wire
